// file: core/amc_pkg.sv
package amc_pkg;
    // register byte offsets on the apb window
    localparam logic [7:0] AMC_OFF_CTL1 = 8'h00;
    localparam logic [7:0] AMC_OFF_CTL2 = 8'h04;
    localparam logic [7:0] AMC_OFF_CTL3 = 8'h08;
    localparam logic [7:0] AMC_OFF_ID1 = 8'h0C;
    localparam logic [7:0] AMC_OFF_STAT = 8'h10;
    // reset values of the cleared registers
    localparam logic [7:0] AMC_RST_CTL1 = 8'h00;
    localparam logic [7:0] AMC_RST_CTL2 = 8'h00;
    localparam logic [7:0] AMC_RST_CTL3 = 8'h00;
    // fixed addresses recognised besides the own address
    localparam logic [6:0] AMC_GC_ADDR = 7'h00;
    localparam logic [6:0] AMC_ARP_ADDR = 7'h61;
    // bits per address byte, including the direction bit
    localparam logic [3:0] AMC_ADDR_BITS = 4'h8;

    // control_one: interrupt, stall and general-call enables
    typedef struct packed {
        logic [3:0] rsv;
        logic general_call_match_en;
        logic stall_after_start_en;
        logic new_match_irq_en;
        logic unit_irq_en;
    } amc_ctl1_s;

    // control_two: low period bits and master clock run
    typedef struct packed {
        logic [6:0] scl_lo;
        logic master_clk_run;
    } amc_ctl2_s;

    // control_three: arp enable and upper period bits
    typedef struct packed {
        logic [4:0] rsv;
        logic arp_match_en;
        logic [1:0] scl_hi;
    } amc_ctl3_s;

    // own_slave_id_first
    typedef struct packed {
        logic slave_id_valid;
        logic [6:0] addr;
    } amc_slave_id_s;

    // unit_status flags, write one to clear
    typedef struct packed {
        logic [5:0] rsv;
        logic stall_after_start_flag;
        logic new_match_flag;
    } amc_stat_s;

    typedef enum logic [1:0] {
        AMC_SL_IDLE,
        AMC_SL_ADDR,
        AMC_SL_ACK,
        AMC_SL_STALL
    } amc_slave_e;
endpackage

// file: core/amc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module amc_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // asynchronous in, synchronous out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // refuse a width the stages cannot hold
    if (WIDTH < 1) begin : g_bad_width
        $error("amc_sync: WIDTH must be at least 1");
    end

    // two stages; idle bus level is high, so reset to ones
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_reg <= '1;
            sync_reg <= '1;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule
`default_nettype wire

// file: core/amc_top.sv
// Function
// - general-call address 00h matches only while its enable bit is one.
// - with stall enabled, stall the bus after the address byte is handled.
// - stall flag stays cleared while the stall enable bit is zero.
// - arp address 110 0001b matches in slave mode only while enabled.
// - scl period is nine bits: two from control three, seven from two.
// - compare first seven received bits to the own address field.
// - first received bit aligns to address bit 6, last to bit 0.
// - own match needs equal address and the valid bit set.
// - valid bit zero means no own-address comparison and no own-address match.
// - own address register has no reset value.
// - master scl low and high times are twice the period in clocks.
// - control three clears on reset.
`timescale 1ns/1ps
`default_nettype none
module amc_top (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // two-wire bus, open drain: enable high pulls the line low
    input wire logic i_scl,
    output logic o_scl,
    output logic o_scl_oe,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    // events
    output logic o_irq,
    output logic [8:0] o_scl_period
);
    import amc_pkg::*;

    amc_ctl1_s ctl1_reg, ctl1_next;
    amc_ctl2_s ctl2_reg, ctl2_next;
    amc_ctl3_s ctl3_reg, ctl3_next;
    amc_slave_id_s id_reg, id_next;
    amc_stat_s stat_reg, stat_next;
    logic [31:0] prdata_reg, prdata_next;
    amc_slave_e sl_reg, sl_next;
    logic [7:0] sh_reg, sh_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [9:0] div_reg, div_next;
    logic scl_low_reg, scl_low_next;
    logic [1:0] bus_sync;
    logic [1:0] bus_prev_reg;
    logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
    logic wr_en, rd_setup, addr_ok;
    logic [8:0] scl_period;
    logic [9:0] div_term;
    logic slave_mode, addr_done, own_hit, gc_hit, arp_hit, match_hit;
    logic [6:0] rx_addr;
    logic stall_set;

    // bus pins pass the synchroniser before any logic sees them
    amc_sync #(
        .WIDTH(2)
    ) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_async({i_scl, i_sda}),
        .o_sync(bus_sync)
    );

    // edge and condition detection on the synchronised lines
    assign scl_s = bus_sync[1];
    assign sda_s = bus_sync[0];
    assign scl_rise = scl_s && !bus_prev_reg[1];
    assign scl_fall = !scl_s && bus_prev_reg[1];
    assign start_det = scl_s && bus_prev_reg[1] && bus_prev_reg[0] && !sda_s;
    assign stop_det = scl_s && bus_prev_reg[1] && !bus_prev_reg[0] && sda_s;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bus_prev_reg <= 2'b11;
        end else begin
            bus_prev_reg <= bus_sync;
        end
    end

    // apb decode; one wait-free access phase after the setup cycle
    assign wr_en = i_psel && i_penable && i_pwrite && addr_ok;
    assign rd_setup = i_psel && !i_penable && !i_pwrite;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !addr_ok;
    assign o_prdata = prdata_reg;

    always_comb begin
        addr_ok = 1'b1;
        prdata_next = prdata_reg;
        if (i_paddr == AMC_OFF_CTL1) begin
            prdata_next = {24'h00_0000, ctl1_reg};
        end else if (i_paddr == AMC_OFF_CTL2) begin
            prdata_next = {24'h00_0000, ctl2_reg};
        end else if (i_paddr == AMC_OFF_CTL3) begin
            prdata_next = {24'h00_0000, ctl3_reg};
        end else if (i_paddr == AMC_OFF_ID1) begin
            prdata_next = {24'h00_0000, id_reg};
        end else if (i_paddr == AMC_OFF_STAT) begin
            prdata_next = {24'h00_0000, stat_reg};
        end else begin
            addr_ok = 1'b0;
            prdata_next = 32'h0000_0000;
        end
        if (!rd_setup) begin
            prdata_next = prdata_reg;
        end
    end

    // software-written control registers; reserved bits read zero
    always_comb begin
        ctl1_next = ctl1_reg;
        ctl2_next = ctl2_reg;
        ctl3_next = ctl3_reg;
        id_next = id_reg;
        if (wr_en && i_paddr == AMC_OFF_CTL1) begin
            ctl1_next = i_pwdata[7:0];
            ctl1_next.rsv = 4'h0;
        end
        if (wr_en && i_paddr == AMC_OFF_CTL2) begin
            ctl2_next = i_pwdata[7:0];
        end
        if (wr_en && i_paddr == AMC_OFF_CTL3) begin
            ctl3_next = i_pwdata[7:0];
            ctl3_next.rsv = 5'h00;
        end
        if (wr_en && i_paddr == AMC_OFF_ID1) begin
            id_next = i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctl1_reg <= AMC_RST_CTL1;
            ctl2_reg <= AMC_RST_CTL2;
            ctl3_reg <= AMC_RST_CTL3;
            prdata_reg <= 32'h0000_0000;
        end else begin
            ctl1_reg <= ctl1_next;
            ctl2_reg <= ctl2_next;
            ctl3_reg <= ctl3_next;
            prdata_reg <= prdata_next;
        end
    end

    // no reset here: content is whatever software last wrote
    always_ff @(posedge i_clk_sys) begin
        id_reg <= id_next;
    end

    // nine-bit period assembled from two registers
    assign scl_period = {ctl3_reg.scl_hi, ctl2_reg.scl_lo};
    assign o_scl_period = scl_period;
    assign div_term = 10'({scl_period, 1'b0} - 10'h001);

    // master clock divider: each half lasts 2 x period system clocks
    always_comb begin
        div_next = div_reg;
        scl_low_next = scl_low_reg;
        if (!ctl2_reg.master_clk_run) begin
            div_next = 10'h000;
            scl_low_next = 1'b0;
        end else if (div_reg >= div_term) begin
            div_next = 10'h000;
            scl_low_next = !scl_low_reg;
        end else begin
            div_next = 10'(div_reg + 10'h001);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            div_reg <= 10'h000;
            scl_low_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            scl_low_reg <= scl_low_next;
        end
    end

    // address recognition; slave mode means the master clock is off
    assign slave_mode = !ctl2_reg.master_clk_run;
    assign rx_addr = sh_reg[7:1];
    assign own_hit = id_reg.slave_id_valid && (rx_addr == id_reg.addr);
    assign gc_hit = ctl1_reg.general_call_match_en && (rx_addr == AMC_GC_ADDR);
    assign arp_hit = ctl3_reg.arp_match_en && (rx_addr == AMC_ARP_ADDR);
    assign match_hit = slave_mode && (own_hit || gc_hit || arp_hit);
    assign addr_done = (sl_reg == AMC_SL_ADDR) && (cnt_reg == AMC_ADDR_BITS) && scl_fall;
    assign stall_set = (sl_reg == AMC_SL_ACK) && scl_fall && ctl1_reg.stall_after_start_en;

    // slave address sequencer; data bytes are not handled
    always_comb begin
        sl_next = sl_reg;
        sh_next = sh_reg;
        cnt_next = cnt_reg;
        case (sl_reg)
            AMC_SL_IDLE: begin
                cnt_next = 4'h0;
            end
            AMC_SL_ADDR: begin
                if (scl_rise && cnt_reg != AMC_ADDR_BITS) begin
                    sh_next = {sh_reg[6:0], sda_s};
                    cnt_next = 4'(cnt_reg + 4'h1);
                end
                if (addr_done) begin
                    sl_next = match_hit ? AMC_SL_ACK : AMC_SL_IDLE;
                end
            end
            AMC_SL_ACK: begin
                if (scl_fall) begin
                    sl_next = stall_set ? AMC_SL_STALL : AMC_SL_IDLE;
                end
            end
            AMC_SL_STALL: begin
                if (!stat_reg.stall_after_start_flag) begin
                    sl_next = AMC_SL_IDLE;
                end
            end
            default: begin
                sl_next = AMC_SL_IDLE;
            end
        endcase
        // in slave mode a start restarts recognition, except while the clock is held
        if (start_det && slave_mode && sl_reg != AMC_SL_STALL) begin
            sl_next = AMC_SL_ADDR;
            cnt_next = 4'h0;
        end else if (stop_det && sl_reg != AMC_SL_STALL) begin
            sl_next = AMC_SL_IDLE;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sl_reg <= AMC_SL_IDLE;
            sh_reg <= 8'h00;
            cnt_reg <= 4'h0;
        end else begin
            sl_reg <= sl_next;
            sh_reg <= sh_next;
            cnt_reg <= cnt_next;
        end
    end

    // status flags: a set in the clearing cycle wins
    always_comb begin
        stat_next = stat_reg;
        if (wr_en && i_paddr == AMC_OFF_STAT) begin
            stat_next.new_match_flag = stat_reg.new_match_flag && !i_pwdata[0];
            stat_next.stall_after_start_flag = stat_reg.stall_after_start_flag && !i_pwdata[1];
        end
        if (addr_done && match_hit) begin
            stat_next.new_match_flag = 1'b1;
        end
        if (stall_set) begin
            stat_next.stall_after_start_flag = 1'b1;
        end
        if (!ctl1_reg.stall_after_start_en) begin
            stat_next.stall_after_start_flag = 1'b0;
        end
        stat_next.rsv = 6'h00;
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stat_reg <= 8'h00;
        end else begin
            stat_reg <= stat_next;
        end
    end

    // pin drive: lines only ever pulled low, released otherwise
    assign o_scl = 1'b0;
    assign o_sda = 1'b0;
    assign o_scl_oe = scl_low_reg || (sl_reg == AMC_SL_STALL);
    assign o_sda_oe = (sl_reg == AMC_SL_ACK);
    assign o_irq = stat_reg.new_match_flag && ctl1_reg.new_match_irq_en
                   && ctl1_reg.unit_irq_en;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);

    sequence seq_addr_done;
        addr_done && slave_mode;
    endsequence

    sequence seq_ack_end;
        (sl_reg == AMC_SL_ACK) && scl_fall;
    endsequence

    AST_GC_MATCH: assert property (seq_addr_done ##0 (rx_addr == AMC_GC_ADDR)
        ##0 ctl1_reg.general_call_match_en |=> stat_reg.new_match_flag ##0 o_sda_oe)
        else $error("general call not matched");
    AST_IRQ_RISE: assert property ($rose(stat_reg.new_match_flag)
        && ctl1_reg.new_match_irq_en && ctl1_reg.unit_irq_en |-> o_irq)
        else $error("irq missing on new match");
    AST_STALL_HOLD: assert property (seq_ack_end ##0 ctl1_reg.stall_after_start_en
        |=> (o_scl_oe && stat_reg.stall_after_start_flag)[*2])
        else $error("scl not held after address byte");
    AST_STALL_OFF: assert property (!ctl1_reg.stall_after_start_en
        |=> !stat_reg.stall_after_start_flag)
        else $error("stall flag set while disabled");
    AST_ARP_OFF: assert property (seq_addr_done ##0 (rx_addr == AMC_ARP_ADDR)
        ##0 !ctl3_reg.arp_match_en ##0 !own_hit |=> !o_sda_oe)
        else $error("arp address acknowledged while disabled");
    AST_HI_BITS: assert property (wr_en && i_paddr == AMC_OFF_CTL3
        |=> o_scl_period[8:7] == $past(i_pwdata[1:0]))
        else $error("upper period bits not taken");
    AST_OWN_MATCH: assert property (seq_addr_done ##0 id_reg.slave_id_valid
        ##0 (sh_reg[7:1] == id_reg.addr) |=> stat_reg.new_match_flag)
        else $error("own address not matched");
    AST_OWN_OFF: assert property (!id_reg.slave_id_valid |-> !own_hit)
        else $error("match reported with address disabled");
    AST_HALF_PERIOD: assert property (ctl2_reg.master_clk_run && $past(ctl2_reg.master_clk_run)
        && $changed(scl_low_reg) |-> $past(div_reg) == $past(div_term))
        else $error("scl half period wrong");
    AST_STALL_RELEASE: assert property ((sl_reg == AMC_SL_STALL)
        && !stat_reg.stall_after_start_flag |=> !o_scl_oe || scl_low_reg)
        else $error("scl not released after flag clear");
endmodule
`default_nettype wire

// file: core/amc_placeholder_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: testbench/amc_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side master: bit-bangs scl/sda, two clocks a quarter, 225 ns a bit with scl released after one clock
module amc_bus_model (
    // clock
    input wire logic i_clk_sys,
    // resolved line levels
    input wire logic i_scl,
    input wire logic i_sda,
    // open-drain pulls, high = line low
    output logic o_scl_low,
    output logic o_sda_low
);
    int hangs = 0;
    // lines released at start; pull-ups then hold them high between frames
    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end
    // quarter of a bit time
    task automatic q;
        repeat (2) @(posedge i_clk_sys);
    endtask
    // release scl; a stalling slave may hold it, so the wait is bounded
    task automatic rise;
        int n;
        o_scl_low <= 1'b0;
        n = 0;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (i_scl !== 1'b1 && n < 400);
        if (n >= 400) hangs++;
    endtask
    // sda falls while scl high, then scl goes low
    task automatic start_cond;
        q();
        o_sda_low <= 1'b1;
        q();
        q();
        o_scl_low <= 1'b1;
    endtask
    // msb first, data changed mid-low; ack sampled mid-high of the ninth bit
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            q();
            o_sda_low <= ~b[i];
            q();
            rise();
            q();
            q();
            o_scl_low <= 1'b1;
        end
        q();
        o_sda_low <= 1'b0;
        q();
        rise();
        q();
        ack = ~i_sda;
        q();
        o_scl_low <= 1'b1;
    endtask
    // sda rises while scl high
    task automatic stop_cond;
        q();
        o_sda_low <= 1'b1;
        q();
        rise();
        q();
        o_sda_low <= 1'b0;
        q();
    endtask
endmodule
`default_nettype wire

// file: testbench/tb_i2c_address_match_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_i2c_address_match_control;
    import amc_pkg::*;
    typedef struct packed {
        logic [7:0] c1, c3, id;
        logic [6:0] ad;
        logic ack, irq;
    } amc_row_s;
    typedef struct packed {
        logic [7:0] a, w, e;
        logic err;
    } amc_reg_s;
    logic clk_sys = 1'b0;
    logic arst_n, psel, penable, pwrite, pready, pslverr, scl_oe, sda_oe, irq;
    logic scl, sda, m_scl_low, m_sda_low, ack, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0] scl_period;
    int num_errors = 0;
    int total_checks = 0;
    int n;
    amc_row_s m;
    amc_reg_s regs [4] = '{'{AMC_OFF_CTL1, 8'hFF, 8'h0F, 1'b0}, '{AMC_OFF_CTL3, 8'hFF, 8'h07, 1'b0},
        '{AMC_OFF_ID1, 8'hA5, 8'hA5, 1'b0}, '{8'h14, 8'hFF, 8'h00, 1'b1}};
    // own, valid off, bit-reversed, general call on/off, arp on/off
    amc_row_s rows [7] = '{'{8'h03, 8'h00, 8'hDA, 7'h5A, 1'b1, 1'b1},
        '{8'h03, 8'h00, 8'h5A, 7'h5A, 1'b0, 1'b0}, '{8'h03, 8'h00, 8'hDA, 7'h2D, 1'b0, 1'b0},
        '{8'h0A, 8'h00, 8'h00, 7'h00, 1'b1, 1'b0}, '{8'h03, 8'h00, 8'h00, 7'h00, 1'b0, 1'b0},
        '{8'h01, 8'h04, 8'h00, 7'h61, 1'b1, 1'b0}, '{8'h03, 8'h00, 8'h00, 7'h61, 1'b0, 1'b0}};
    // pull-ups: a line is low only while someone pulls it
    assign scl = ~(scl_oe | m_scl_low);
    assign sda = ~(sda_oe | m_sda_low);
    always #12.5 clk_sys = ~clk_sys;
    amc_top DUT (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_scl(scl), .o_scl(), .o_scl_oe(scl_oe),
        .i_sda(sda), .o_sda(), .o_sda_oe(sda_oe), .o_irq(irq), .o_scl_period(scl_period));
    amc_bus_model BUS (.i_clk_sys(clk_sys), .i_scl(scl), .i_sda(sda),
        .o_scl_low(m_scl_low), .o_sda_low(m_sda_low));
    task automatic give_verdict;
        if (num_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // one apb transfer; entered at a rising edge, leaves one idle cycle behind
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd_o, output logic err_o);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            num_errors++;
            give_verdict();
        end
        rd_o = prdata;
        err_o = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        apb(0, AMC_OFF_CTL3, 32'h0000_0000, rd, err);
        `CHK(rd, 32'h0000_0000)
        foreach (regs[i]) begin
            apb(1, regs[i].a, {24'h00_0000, regs[i].w}, rd, err);
            `CHK(err, regs[i].err)
            apb(0, regs[i].a, 32'h0000_0000, rd, err);
            `CHK(rd, {24'h00_0000, regs[i].e})
        end
        `CHK(scl_period, 9'h180)
        // slave matching: one frame per row, flags cleared after each
        foreach (rows[i]) begin
            m = rows[i];
            apb(1, AMC_OFF_CTL1, {24'h00_0000, m.c1}, rd, err);
            apb(1, AMC_OFF_CTL3, {24'h00_0000, m.c3}, rd, err);
            apb(1, AMC_OFF_ID1, {24'h00_0000, m.id}, rd, err);
            BUS.start_cond();
            BUS.send_byte({m.ad, 1'b0}, ack);
            BUS.stop_cond();
            `CHK(ack, m.ack)
            `CHK(irq, m.irq)
            apb(0, AMC_OFF_STAT, 32'h0000_0000, rd, err);
            `CHK(rd[1:0], {1'b0, m.ack})
            apb(1, AMC_OFF_STAT, 32'h0000_0003, rd, err);
            `CHK(irq, 1'b0)
        end
        // stall after a matched address, released only by software
        apb(1, AMC_OFF_CTL1, 32'h0000_0004, rd, err);
        apb(1, AMC_OFF_ID1, 32'h0000_00DA, rd, err);
        BUS.start_cond();
        BUS.send_byte(8'hB4, ack);
        repeat (40) @(posedge clk_sys);
        `CHK(scl_oe, 1'b1)
        apb(0, AMC_OFF_STAT, 32'h0000_0000, rd, err);
        `CHK(rd[1:0], 2'b11)
        apb(1, AMC_OFF_STAT, 32'h0000_0002, rd, err);
        @(posedge clk_sys);
        `CHK(scl_oe, 1'b0)
        BUS.stop_cond();
        // master clock: P = 131 uses the upper bit 7 path, low phase 262 clocks
        apb(1, AMC_OFF_CTL3, 32'h0000_0001, rd, err);
        apb(1, AMC_OFF_CTL2, 32'h0000_0006, rd, err);
        `CHK(scl_period, 9'h083)
        apb(1, AMC_OFF_CTL2, 32'h0000_0007, rd, err);
        n = 0;
        while (scl_oe !== 1'b1 && n < 1000) begin
            @(posedge clk_sys);
            n++;
        end
        n = 0;
        while (scl_oe === 1'b1 && n < 1000) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK(n, 262)
        apb(1, AMC_OFF_CTL2, 32'h0000_0000, rd, err);
        // second reset in mid-run
        apb(1, AMC_OFF_CTL3, 32'h0000_0007, rd, err);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        apb(0, AMC_OFF_CTL3, 32'h0000_0000, rd, err);
        `CHK(rd, 32'h0000_0000)
        `CHK(scl_period, 9'h000)
        // own address keeps the last written value across reset
        apb(0, AMC_OFF_ID1, 32'h0000_0000, rd, err);
        `CHK(rd, 32'h0000_00DA)
        `CHK(BUS.hangs, 0)
        give_verdict();
    end
endmodule
`default_nettype wire
